/* File: core/pchbp_defs.vh */
`ifndef PCHBP_DEFS_VH
`define PCHBP_DEFS_VH
// register window geometry
`define PCHBP_NUM_REGS       32
`define PCHBP_ADDR_W         5
// attribute space redirect offset into ram
`define PCHBP_ATTR_OFS       16'h0400
// hardware register indices
`define PCHBP_REG_AUX_BASE   5'h00
`define PCHBP_REG_AUX_OFS    5'h01
`define PCHBP_REG_AUX_DATA   5'h02
`define PCHBP_REG_INT_CTRL   5'h03
`define PCHBP_REG_BP0_PTR    5'h04
`define PCHBP_REG_BP0_END    5'h05
`define PCHBP_REG_BP0_DATA   5'h06
`define PCHBP_REG_BP1_PTR    5'h07
`define PCHBP_REG_BP1_END    5'h08
`define PCHBP_REG_BP1_DATA   5'h09
`define PCHBP_REG_INT_ACK    5'h0a
// memory mapped registers start here
`define PCHBP_MM_FIRST       5'h10
`define PCHBP_MM_BASE        16'h0100
// block geometry: 128 bytes is 64 words, link word stored in last word
`define PCHBP_BLK_WORDS      64
`define PCHBP_BLK_MASK       16'h003f
// interrupt control bit positions
`define PCHBP_INT_PULSE_BIT  0
`define PCHBP_INT_EN_BIT     1
// pulse width in cycles
`define PCHBP_PULSE_CYC      4'h4
`endif

/* File: core/pchbp_port.v */
`timescale 1ns/1ns
// Functional notes
// - request line is ready/busy, then interrupt
// - level or pulse interrupt, level default
// - thirty-two word registers in io space
// - hardware registers answer without arbitration, except the aux and path data registers
// - aux base and offset write-only
// - aux data reaches any ram word
// - every cycle gets a sync wait
// - memory registers arbitrate before completing
// - attribute space maps to base plus 0x400
// - two independent buffer paths with pointers
// - path pointer auto-increments per access
// - block end follows stored link
// - link follow may add wait
// - writes past buffer end are dropped
// - one shared pre-read, invalidated elsewhere
// - input ack on valid io read
// - io strobes honoured only after init
`include "pchbp_defs.vh"
module pchbp_port #(
    parameter AW        = 16,
    parameter CIS_WORDS = 16
) (
    input  wire          sys_clk_i,
    input  wire          rst_b_i,
    // host side, sampled synchronously
    input  wire          host_ce1_n_i,
    input  wire          host_ce2_n_i,
    input  wire          host_reg_n_i,
    input  wire          host_io_read_n_i,
    input  wire          host_io_write_n_i,
    input  wire          host_attr_read_n_i,
    input  wire          host_attr_write_n_i,
    input  wire [9:0]    host_addr_i,
    input  wire [15:0]   host_data_i,
    output reg  [15:0]   host_data_o,
    output wire          host_data_oe_n_o,
    output wire          host_wait_n_o,
    output wire          host_input_ack_n_o,
    output wire          host_request_line_n_o,
    // io mode switch from configuration logic
    input  wire          io_mode_i,
    // interrupt source level and event pulse
    input  wire          int_src_i,
    // nonvolatile table source
    input  wire          nv_valid_i,
    input  wire [15:0]   nv_data_i,
    output wire          nv_ready_o,
    // ram arbitration
    output reg           mem_req_o,
    input  wire          mem_gnt_i,
    output reg           mem_we_o,
    output reg  [AW-1:0] mem_addr_o,
    output reg  [15:0]   mem_wdata_o,
    input  wire [15:0]   mem_rdata_i
);
    // fsm states
    localparam S_LOAD  = 3'd0;
    localparam S_IDLE  = 3'd1;
    localparam S_SYNC  = 3'd2;
    localparam S_MEM   = 3'd3;
    localparam S_LINK  = 3'd4;
    localparam S_DONE  = 3'd5;
    localparam S_PRE   = 3'd6;
    localparam S_HOLD  = 3'd7;
    // access kinds
    localparam K_HW    = 2'd0;
    localparam K_MM    = 2'd1;
    localparam K_BUF   = 2'd2;
    localparam K_ATTR  = 2'd3;
    // constants brought to the ram address width once, so no sum below pads or drops bits
    localparam [AW-1:0] ATTR_BASE = `PCHBP_ATTR_OFS;
    localparam [AW-1:0] MM_BASE   = `PCHBP_MM_BASE;
    localparam [AW-1:0] BLK_MASK  = `PCHBP_BLK_MASK;
    localparam [AW-1:0] LOAD_LAST = CIS_WORDS - 1;

    reg  [2:0]    state_q;          // main sequencer
    reg  [1:0]    kind_q;           // access class latched at cycle start
    reg           wr_q;             // latched direction
    reg           path_q;           // buffer path index
    reg  [4:0]    idx_q;            // register index
    reg  [15:0]   wdat_q;           // posted write data
    reg           init_done_q;      // card table copied
    reg  [AW-1:0] load_ptr_q;       // table copy pointer
    reg  [AW-1:0] aux_base_q;       // aux window base
    reg  [AW-1:0] aux_ofs_q;        // aux window offset
    reg  [AW-1:0] ptr_q [0:1];      // buffer path pointers
    reg  [AW-1:0] end_q [0:1];      // buffer path limits
    reg  [15:0]   pre_q;            // shared pre-read holder
    reg           pre_vld_q;        // pre-read holder valid
    reg           pre_path_q;       // path owning the pre-read
    reg           pulse_mode_q;     // interrupt signalling mode
    reg           int_en_q;         // interrupt enable
    reg           int_pend_q;       // latched level interrupt
    reg           int_src_q;        // previous source for edge
    reg  [3:0]    pulse_cnt_q;      // pulse stretch counter
    // two-entry skid buffer for the nv table stream
    reg  [15:0]   fifo_q [0:1];
    reg  [1:0]    fifo_cnt_q;
    reg           fifo_rd_q;
    reg           fifo_wr_q;

    wire          io_ok   = init_done_q & io_mode_i;
    wire          card_en = ~host_ce1_n_i & ~host_ce2_n_i & ~host_reg_n_i;
    wire          io_rd   = card_en & ~host_io_read_n_i & io_ok;
    wire          io_wr   = card_en & ~host_io_write_n_i & io_ok;
    wire          at_rd   = card_en & ~host_attr_read_n_i;
    wire          at_wr   = card_en & ~host_attr_write_n_i;
    wire          any_cyc = io_rd | io_wr | at_rd | at_wr;
    wire [4:0]    hidx    = host_addr_i[5:1];
    wire          busy    = (state_q != S_IDLE) & (state_q != S_HOLD);
    wire          fifo_pop = (state_q == S_LOAD) && (fifo_cnt_q != 2'd0) && mem_gnt_i;

    // classify a register index once, used only when a cycle starts
    function [1:0] kind_of;
        input [4:0] i;
        begin
            if (i >= `PCHBP_MM_FIRST) begin
                kind_of = K_MM;
            end else if (i == `PCHBP_REG_BP0_DATA || i == `PCHBP_REG_BP1_DATA || i == `PCHBP_REG_AUX_DATA) begin
                kind_of = K_BUF;
            end else begin
                kind_of = K_HW;
            end
        end
    endfunction

    // the table loads through a two-entry buffer so a memory stall drops nothing
    assign nv_ready_o = (fifo_cnt_q != 2'd2) & ~init_done_q;
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fifo_cnt_q <= 2'd0;
            fifo_rd_q  <= 1'b0;
            fifo_wr_q  <= 1'b0;
        end else begin
            if (nv_valid_i && nv_ready_o) begin
                fifo_q[fifo_wr_q] <= nv_data_i;
                fifo_wr_q         <= ~fifo_wr_q;
            end
            if (fifo_pop) begin
                fifo_rd_q <= ~fifo_rd_q;
            end
            fifo_cnt_q <= fifo_cnt_q + {1'b0, nv_valid_i & nv_ready_o} - {1'b0, fifo_pop};
        end
    end

    // request line: ready/busy before init, interrupt after
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            int_pend_q  <= 1'b0;
            int_src_q   <= 1'b0;
            pulse_cnt_q <= 4'h0;
        end else begin
            int_src_q <= int_src_i;
            // level mode holds until acked or disabled; set beats clear
            if (int_src_i & ~int_src_q & int_en_q) begin
                int_pend_q <= 1'b1;
            end else if (!int_en_q || (state_q == S_SYNC && wr_q && kind_q == K_HW
                         && idx_q == `PCHBP_REG_INT_ACK)) begin
                int_pend_q <= 1'b0;
            end
            if (int_src_i & ~int_src_q & int_en_q & pulse_mode_q) begin
                pulse_cnt_q <= `PCHBP_PULSE_CYC;
            end else if (pulse_cnt_q != 4'h0) begin
                pulse_cnt_q <= pulse_cnt_q - 4'h1;
            end
        end
    end
    // low means busy before init and interrupt afterwards
    assign host_request_line_n_o = !init_done_q ? 1'b0 :
                                   pulse_mode_q ? (pulse_cnt_q == 4'h0) : ~int_pend_q;

    // wait asserted while a cycle is being synchronised or arbitrated
    assign host_wait_n_o      = ~(any_cyc & busy);
    assign host_input_ack_n_o = ~io_rd;
    assign host_data_oe_n_o   = ~((io_rd | at_rd) & (state_q == S_HOLD));

    // main sequencer
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_q      <= S_LOAD;
            init_done_q  <= 1'b0;
            load_ptr_q   <= {AW{1'b0}};
            kind_q       <= K_HW;
            wr_q         <= 1'b0;
            path_q       <= 1'b0;
            idx_q        <= 5'h00;
            wdat_q       <= 16'h0000;
            aux_base_q   <= {AW{1'b0}};
            aux_ofs_q    <= {AW{1'b0}};
            ptr_q[0]     <= {AW{1'b0}};
            ptr_q[1]     <= {AW{1'b0}};
            end_q[0]     <= {AW{1'b0}};
            end_q[1]     <= {AW{1'b0}};
            pre_q        <= 16'h0000;
            pre_vld_q    <= 1'b0;
            pre_path_q   <= 1'b0;
            pulse_mode_q <= 1'b0;
            int_en_q     <= 1'b0;
            host_data_o  <= 16'h0000;
            mem_req_o    <= 1'b0;
            mem_we_o     <= 1'b0;
            mem_addr_o   <= {AW{1'b0}};
            mem_wdata_o  <= 16'h0000;
        end else begin
            case (state_q)
            S_LOAD: begin
                // copy the card table into ram at the attribute window
                mem_req_o   <= (fifo_cnt_q != 2'd0);
                mem_we_o    <= 1'b1;
                mem_addr_o  <= ATTR_BASE + load_ptr_q;
                mem_wdata_o <= fifo_q[fifo_rd_q];
                if (fifo_pop) begin
                    // drop the request a cycle so the next word leaves with its own address
                    mem_req_o  <= 1'b0;
                    load_ptr_q <= load_ptr_q + {{(AW-1){1'b0}}, 1'b1};
                    if (load_ptr_q == LOAD_LAST) begin
                        init_done_q <= 1'b1;
                        state_q     <= S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                if (any_cyc) begin
                    wr_q   <= io_wr | at_wr;
                    wdat_q <= host_data_i;
                    idx_q  <= hidx;
                    path_q <= (hidx == `PCHBP_REG_BP1_DATA);
                    kind_q <= (at_rd | at_wr) ? K_ATTR : kind_of(hidx);
                    state_q <= S_SYNC;
                end
            end
            S_SYNC: begin
                state_q <= S_MEM;
                if (kind_q == K_HW) begin
                    // hardware registers complete here, no arbitration
                    state_q <= S_HOLD;
                    if (wr_q) begin
                        if (idx_q == `PCHBP_REG_AUX_BASE) aux_base_q <= wdat_q[AW-1:0];
                        else if (idx_q == `PCHBP_REG_AUX_OFS) aux_ofs_q <= wdat_q[AW-1:0];
                        else if (idx_q == `PCHBP_REG_BP0_PTR) ptr_q[0] <= wdat_q[AW-1:0];
                        else if (idx_q == `PCHBP_REG_BP1_PTR) ptr_q[1] <= wdat_q[AW-1:0];
                        else if (idx_q == `PCHBP_REG_BP0_END) end_q[0] <= wdat_q[AW-1:0];
                        else if (idx_q == `PCHBP_REG_BP1_END) end_q[1] <= wdat_q[AW-1:0];
                        else if (idx_q == `PCHBP_REG_INT_CTRL) begin
                            pulse_mode_q <= wdat_q[`PCHBP_INT_PULSE_BIT];
                            int_en_q     <= wdat_q[`PCHBP_INT_EN_BIT];
                        end
                        if (idx_q == `PCHBP_REG_BP0_PTR || idx_q == `PCHBP_REG_BP1_PTR) begin
                            pre_vld_q <= 1'b0;
                        end
                    end else begin
                        // aux base and offset registers are write-only and read back zero
                        if (idx_q == `PCHBP_REG_INT_CTRL) host_data_o <= {14'h0000, int_en_q, pulse_mode_q};
                        else if (idx_q == `PCHBP_REG_BP0_PTR) host_data_o <= ptr_q[0][15:0];
                        else if (idx_q == `PCHBP_REG_BP1_PTR) host_data_o <= ptr_q[1][15:0];
                        else host_data_o <= 16'h0000;
                    end
                end else if (kind_q == K_BUF && idx_q != `PCHBP_REG_AUX_DATA) begin
                    if (!wr_q && pre_vld_q && pre_path_q == path_q) begin
                        // pre-read hit skips arbitration
                        host_data_o <= pre_q;
                        ptr_q[path_q] <= ptr_q[path_q] + {{(AW-1){1'b0}}, 1'b1};
                        state_q <= S_LINK;
                    end else if (wr_q && ptr_q[path_q] >= end_q[path_q]) begin
                        state_q <= S_HOLD;
                    end else begin
                        mem_req_o <= 1'b1;
                    end
                    pre_vld_q <= 1'b0;
                end else begin
                    if (!wr_q) pre_vld_q <= 1'b0;
                    mem_req_o <= 1'b1;
                end
                mem_we_o    <= wr_q;
                mem_wdata_o <= wdat_q;
                if (kind_q == K_ATTR) mem_addr_o <= ATTR_BASE + {{(AW-9){1'b0}}, host_addr_i[9:1]};
                else if (kind_q == K_MM) mem_addr_o <= MM_BASE + {{(AW-5){1'b0}}, idx_q};
                else if (idx_q == `PCHBP_REG_AUX_DATA) mem_addr_o <= aux_base_q + aux_ofs_q;
                else mem_addr_o <= ptr_q[path_q];
            end
            S_MEM: begin
                // wait for the arbiter
                if (mem_gnt_i) begin
                    mem_req_o <= 1'b0;
                    if (!wr_q) host_data_o <= mem_rdata_i;
                    if (kind_q == K_BUF && idx_q != `PCHBP_REG_AUX_DATA) begin
                        ptr_q[path_q] <= ptr_q[path_q] + {{(AW-1){1'b0}}, 1'b1};
                        state_q <= S_LINK;
                    end else begin
                        state_q <= S_HOLD;
                    end
                end
            end
            S_LINK: begin
                // last word of a block holds the next block address
                if ((ptr_q[path_q] & BLK_MASK) == BLK_MASK) begin
                    mem_req_o  <= 1'b1;
                    mem_we_o   <= 1'b0;
                    mem_addr_o <= ptr_q[path_q];
                    state_q    <= S_DONE;
                end else begin
                    state_q <= wr_q ? S_HOLD : S_PRE;
                    mem_req_o  <= ~wr_q;
                    mem_we_o   <= 1'b0;
                    mem_addr_o <= ptr_q[path_q];
                end
            end
            S_DONE: begin
                if (mem_gnt_i) begin
                    ptr_q[path_q] <= mem_rdata_i[AW-1:0];
                    mem_req_o     <= 1'b0;
                    state_q       <= S_LINK;
                end
            end
            S_PRE: begin
                if (mem_gnt_i) begin
                    pre_q      <= mem_rdata_i;
                    pre_vld_q  <= 1'b1;
                    pre_path_q <= path_q;
                    mem_req_o  <= 1'b0;
                    state_q    <= S_HOLD;
                end
            end
            S_HOLD: begin
                // stay until the host drops its strobes
                if (!any_cyc) state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* File: tb/pchbp_ram_mdl.sv */
`timescale 1ns/1ns
// ram arbiter and table source that sit behind the host port
module pchbp_ram_mdl #(
    parameter NW = 4
) (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        req_i,
    input  wire        we_i,
    input  wire [15:0] addr_i,
    input  wire [15:0] wdata_i,
    output reg         gnt_o,
    output reg  [15:0] rdata_o,
    output wire        nv_valid_o,
    output wire [15:0] nv_data_o,
    input  wire        nv_ready_i
);
    reg [15:0] ram [0:65535];  // word store, preloaded by the bench
    reg [1:0]  dly_q;          // cycles waited for this grant
    reg        slow_q;         // every other grant is made to wait
    reg [7:0]  k_q;            // table words handed over
    reg        ph_q;           // one idle cycle after each word
    // one grant pulse per request; read data is scrambled outside grants
    always @(posedge clk_i) begin
        gnt_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        if (!rst_b_i) begin
            dly_q  <= 2'h0;
            slow_q <= 1'b0;
        end else if (!req_i || gnt_o) begin
            dly_q <= 2'h0;
        end else if (dly_q >= (slow_q ? 2'h3 : 2'h0)) begin
            gnt_o   <= 1'b1;
            slow_q  <= !slow_q;
            rdata_o <= ram[addr_i];
            if (we_i) begin
                ram[addr_i] <= wdata_i;
            end
        end else begin
            dly_q <= dly_q + 2'h1;
        end
    end
    // words are held until taken, so a stall by the port loses none
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            k_q    <= 8'h00;
            ph_q   <= 1'b1;
        end else begin
            ph_q <= !(nv_valid_o && nv_ready_i);
            k_q  <= k_q + {7'h00, nv_valid_o && nv_ready_i};
        end
    end
    assign nv_valid_o = ph_q && (k_q < NW);
    assign nv_data_o  = nv_valid_o ? {8'ha5, k_q} : {8'h5a, ~k_q};
endmodule

/* File: tb/pchbp_port_chk.sv */
`timescale 1ns/1ns
// watches the host port pins for timing and ownership slips
module pchbp_port_chk #(
    parameter AW        = 16,
    parameter CIS_WORDS = 16
) (
    input wire          sys_clk_i,
    input wire          rst_b_i,
    input wire          host_ce1_n_i,
    input wire          host_ce2_n_i,
    input wire          host_reg_n_i,
    input wire          host_io_read_n_i,
    input wire          host_io_write_n_i,
    input wire [9:0]    host_addr_i,
    input wire [15:0]   host_data_i,
    input wire          host_wait_n_o,
    input wire          host_input_ack_n_o,
    input wire          host_request_line_n_o,
    input wire          io_mode_i,
    input wire          nv_valid_i,
    input wire          nv_ready_o,
    input wire          mem_req_o,
    input wire          mem_gnt_i,
    input wire [AW-1:0] mem_addr_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    reg  [7:0] nv_cnt_q;  // table words taken so far
    reg        rdy_q;     // ready has been shown once
    reg  [1:0] ctl_q;     // copy of interrupt control, bit0 pulse
    wire ok = !host_ce1_n_i && !host_ce2_n_i && !host_reg_n_i && rdy_q && io_mode_i;
    // shadow state so properties can see init and interrupt mode
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            nv_cnt_q <= 8'h00;
            rdy_q    <= 1'b0;
            ctl_q    <= 2'h0;
        end else begin
            nv_cnt_q <= nv_cnt_q + {7'h00, nv_valid_i && nv_ready_o};
            rdy_q    <= rdy_q || host_request_line_n_o;
            if (ok && $fell(host_io_write_n_i) && host_addr_i[5:1] == 5'h03) begin
                ctl_q <= host_data_i[1:0];
            end
        end
    end
    busy_till_load_a: assert property ((nv_cnt_q < CIS_WORDS) |-> !host_request_line_n_o)
        else $error("ready shown before table loaded");
    ack_cause_a: assert property (!host_input_ack_n_o |-> ok && !host_io_read_n_i)
        else $error("input ack without a valid io read");
    ack_given_a: assert property (ok && !host_io_read_n_i |-> !host_input_ack_n_o)
        else $error("valid io read without input ack");
    sync_wait_a: assert property (ok && $fell(host_io_write_n_i) |=> !host_wait_n_o)
        else $error("no sync wait on io cycle");
    hw_short_a: assert property (ok && $fell(host_io_write_n_i) && host_addr_i[5:1] < 5'h02 && !mem_req_o
        |=> !host_wait_n_o ##1 host_wait_n_o)
        else $error("hardware register cycle not two cycles");
    req_hold_a: assert property (mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("ram request dropped before grant");
    level_stay_a: assert property (rdy_q && !ctl_q[0] && !host_request_line_n_o && host_io_write_n_i
        && $past(host_io_write_n_i) |=> !host_request_line_n_o)
        else $error("level interrupt removed without host write");
    pulse_len_a: assert property (rdy_q && ctl_q[0] && $fell(host_request_line_n_o)
        |-> !host_request_line_n_o [*4] ##1 host_request_line_n_o)
        else $error("interrupt pulse not four cycles");
    cover property (ok && $fell(host_io_write_n_i));
    cover property (!host_input_ack_n_o);
    cover property (rdy_q && ctl_q[0] && $fell(host_request_line_n_o));
endmodule
bind pchbp_port pchbp_port_chk #(.AW(AW), .CIS_WORDS(CIS_WORDS)) u_chk (.*);

/* File: tb/pchbp_port_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module pchbp_port_tb;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i, host_ce1_n_i, host_ce2_n_i, host_reg_n_i, io_mode_i, int_src_i, acks, oe;
    logic        host_io_read_n_i, host_io_write_n_i, host_attr_read_n_i;
    wire         host_attr_write_n_i = 1'b1;  // attribute writes stay idle
    logic [9:0]  host_addr_i;
    logic [15:0] host_data_i, q;
    wire  [15:0] host_data_o, mem_wdata_o, mem_rdata_i, nv_data_i, mem_addr_o;
    wire         host_data_oe_n_o, host_wait_n_o, host_input_ack_n_o, host_request_line_n_o;
    wire         nv_valid_i, nv_ready_o, mem_req_o, mem_gnt_i, mem_we_o;
    integer      n_mismatch = 0, compares = 0, i, n;
    always #10 sys_clk_i = ~sys_clk_i;
    pchbp_port #(.AW(16), .CIS_WORDS(4)) dut (.*);
    pchbp_ram_mdl #(.NW(4)) mdl (.clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .gnt_o(mem_gnt_i), .rdata_o(mem_rdata_i),
        .nv_valid_o(nv_valid_i), .nv_data_o(nv_data_i), .nv_ready_i(nv_ready_o));
    // one host cycle: kind 0 attribute read, 1 io write, 2 io read; held until wait releases
    task automatic cyc(input [1:0] k, input [9:0] a, input [15:0] d);
        integer w;
        begin
            @(posedge sys_clk_i);
            {host_ce1_n_i, host_ce2_n_i, host_reg_n_i} <= 3'h0;
            {host_io_read_n_i, host_io_write_n_i, host_attr_read_n_i} <= ~(3'h1 << k);
            host_addr_i <= a;
            host_data_i <= d;
            acks = 1'b0;
            w = 0;
            @(posedge sys_clk_i);
            do begin
                @(posedge sys_clk_i);
                #1;
                w++;
                if (host_input_ack_n_o === 1'b0) acks = 1'b1;
            end while (host_wait_n_o !== 1'b1 && w < 300);
            if (w >= 300) `CHK("wait release", 1'b1, host_wait_n_o)
            q = host_data_o;
            oe = host_data_oe_n_o;
            @(posedge sys_clk_i);
            {host_ce1_n_i, host_ce2_n_i, host_reg_n_i, host_io_read_n_i, host_io_write_n_i,
                host_attr_read_n_i} <= 6'h3f;
        end
    endtask
    task automatic wr(input [4:0] r, input [15:0] d);
        cyc(2'h1, {4'h0, r, 1'b0}, d);
    endtask
    task automatic rd(input [4:0] r);
        cyc(2'h2, {4'h0, r, 1'b0}, 16'h0000);
    endtask
    // busy until the table is in ram, then table readable; io refused before io mode
    task t_init;
        begin
            `CHK("busy line", 1'b0, host_request_line_n_o)
            for (n = 0; host_request_line_n_o !== 1'b1 && n < 500; n++) @(posedge sys_clk_i);
            #1;
            `CHK("ready line", 1'b1, host_request_line_n_o)
            `CHK("table in ram", 16'ha502, mdl.ram[16'h0402])
            cyc(2'h0, 10'h004, 16'h0000);
            `CHK("table read", 16'ha502, q)
            rd(5'h02);
            `CHK("ack before io mode", 1'b0, acks)
            `CHK("drive before io mode", 1'b1, oe)
            io_mode_i <= 1'b1;
            $display("test init done");
        end
    endtask
    // aux window steered by offset, and a memory mapped register
    task t_regs;
        begin
            wr(5'h00, 16'h0300);
            wr(5'h01, 16'h0005);
            wr(5'h02, 16'h1234);
            wr(5'h01, 16'h0006);
            wr(5'h02, 16'h5678);
            wr(5'h01, 16'h0005);
            rd(5'h02);
            `CHK("aux read", 16'h1234, q)
            `CHK("ack on io read", 1'b1, acks)
            `CHK("read drive", 1'b0, oe)
            wr(5'h11, 16'hbeef);
            `CHK("mm in ram", 16'hbeef, mdl.ram[16'h0111])
            $display("test regs done");
        end
    endtask
    // writes past end dropped; reads on one path interleaved with the other path
    task t_bap;
        begin
            mdl.ram[16'h0203] = 16'h0bad;
            wr(5'h04, 16'h0200);
            wr(5'h05, 16'h0203);
            for (i = 0; i < 4; i++) wr(5'h06, {12'hc00, i[3:0]});
            `CHK("drop past end", 16'h0bad, mdl.ram[16'h0203])
            wr(5'h04, 16'h0210);
            wr(5'h05, 16'h0220);
            wr(5'h07, 16'h0200);
            wr(5'h08, 16'h0210);
            for (i = 0; i < 3; i++) begin
                rd(5'h09);
                `CHK("path read", ((i == 0) ? 16'hc000 : {12'hd00, i[3:0]}), q)
                // change the word already pre-read; only a dropped pre-read returns the new value
                mdl.ram[16'h0201 + i] = {12'hd00, i[3:0] + 4'h1};
                rd(5'h11);
                `CHK("mm between", 16'hbeef, q)
                wr(5'h06, {12'he00, i[3:0]});
            end
            `CHK("path write", 16'he002, mdl.ram[16'h0212])
            $display("test bap done");
        end
    endtask
    // pointer at the last data word of a block jumps through the stored link
    task t_link;
        begin
            mdl.ram[16'h023e] = 16'h7777;
            mdl.ram[16'h023f] = 16'h0300;
            mdl.ram[16'h0300] = 16'h8888;
            wr(5'h04, 16'h023e);
            wr(5'h05, 16'h0400);
            rd(5'h06);
            `CHK("before link", 16'h7777, q)
            rd(5'h06);
            `CHK("after link", 16'h8888, q)
            $display("test link done");
        end
    endtask
    // level interrupt held until acknowledged, then a four cycle pulse
    task t_irq;
        begin
            wr(5'h03, 16'h0002);
            int_src_i <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
            int_src_i <= 1'b0;
            repeat (6) @(posedge sys_clk_i);
            #1;
            `CHK("level held", 1'b0, host_request_line_n_o)
            wr(5'h0a, 16'hffff);
            repeat (3) @(posedge sys_clk_i);
            #1;
            `CHK("irq cleared", 1'b1, host_request_line_n_o)
            wr(5'h03, 16'h0003);
            int_src_i <= 1'b1;
            n = 0;
            for (i = 0; i < 12; i++) begin
                @(posedge sys_clk_i);
                #1;
                if (host_request_line_n_o === 1'b0) n++;
            end
            `CHK("pulse width", 4, n)
            $display("test irq done");
        end
    endtask
    task conclude;
        begin
            $display("compares %0d n_mismatch %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // a hang is cut short well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        `CHK("watchdog", 1'b1, 1'b0)
        conclude;
    end
    initial begin
        rst_b_i = 1'b0;
        {host_ce1_n_i, host_ce2_n_i, host_reg_n_i, host_io_read_n_i, host_io_write_n_i, host_attr_read_n_i} = 6'h3f;
        {io_mode_i, int_src_i, acks} = 3'h0;
        host_addr_i = 10'h000;
        host_data_i = 16'h0000;
        repeat (6) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        t_init;
        t_regs;
        t_bap;
        t_link;
        t_irq;
        conclude;
    end
endmodule
